// file: fcs_ctrl.sv
// Control core of the loop clock synth: register slave, shadowed config,
// glitch-free reference switch and switch-done event.
// Assumes one aclk domain; reference pins arrive asynchronously.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Registers work ungated; gated writes are synchronised
// - Reference picked from four inputs by select
// - Run bit starts and stops the loop
// - Running writes shadowed until apply written
// - Active reference readable in status field
// - Switch completion raises done event and output
// - Oscillator is reference times N.K times ratio
// - N, numerator, denominator plain unsigned integers
// - Output ratio code n divides by n+1
// - Error gain is two to the code, clamped at code eight
// - Integer multiplier ten bits, reset 2EEh
// - Reference codes: A, B, frame, bit clock
// - Denominator sixteen bits, reset zero
// - Fractional enable selects mode, reset zero
module fcs_ctrl import fcs_pkg::*; (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Reference pins
   input wire logic master_clk_in_a,
   input wire logic master_clk_in_b,
   input wire logic frame_clk_in_a,
   input wire logic bit_clk_in_a,
   // Active loop configuration towards the analog loop
   output logic loop_run,
   output logic ref_tick,
   output logic [1:0] loop_ref_active_status,
   output logic [4:0] vco_mult,
   output logic [6:0] out_ratio,
   output logic [9:0] loop_integer_mult,
   output logic [15:0] loop_frac_numerator,
   output logic [15:0] loop_frac_denominator,
   output logic loop_fractional_on,
   output logic [1:0] loop_dither_select,
   output logic [8:0] err_gain_mult,
   output logic loop_low_ref_mode,
   // Switch-done event
   output logic switch_done_pulse,
   output logic loop_switch_done_flag,
   output logic switch_gpio
);
   fcs_ref_if refs ();
   fcs_cfg_t cfg_q, cfg_d, act_q;
   fcs_sw_t st_q;
   logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic arready_q, rvalid_q;
   logic [31:0] rdata_q, wdata_q;
   logic [3:0] wstrb_q;
   logic [IDX_W-1:0] aw_idx_q;
   logic [1:0] sync_cnt_q, pend_src_q;
   logic run_q, gate_q, gpio_sel_q, flag_q, seen_old_q, done_q;
   logic [2:0] pcnt_q;
   logic tick_q, gpio_q;
   logic [4:0] vco_mult_q;
   logic [6:0] out_ratio_q;
   logic [8:0] gain_q;

   // Rising edges of A, B, frame and bit clock in code order
   fcs_ref_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ref_pins({bit_clk_in_a, frame_clk_in_a, master_clk_in_b,
         master_clk_in_a}),
      .refs(refs)
   );

   function automatic logic [15:0] merge16(input logic [15:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      merge16 = {strb[1] ? nw[15:8] : old[15:8],
         strb[0] ? nw[7:0] : old[7:0]};
   endfunction

   // Write path
   wire both_w = aw_have_q & w_have_q & ~bvalid_q;
   // Gated writes wait out a synchroniser delay into the core domain
   wire commit_w = both_w & (~gate_q | (sync_cnt_q == WR_SYNC_CYC));
   wire [1:0] sync_cnt_d = (both_w & ~commit_w) ?
      sync_cnt_q + 2'h1 : 2'h0;
   wire hit = (aw_idx_q >= RUN_IDX) && (aw_idx_q <= EVT_IDX);
   wire wr_run = commit_w && aw_idx_q == RUN_IDX;
   wire wr_ratio = commit_w && aw_idx_q == RATIO_IDX;
   wire wr_num = commit_w && aw_idx_q == NUM_IDX;
   wire wr_intg = commit_w && aw_idx_q == INTG_IDX;
   wire wr_ref = commit_w && aw_idx_q == REF_IDX;
   wire wr_sw = commit_w && aw_idx_q == SW_IDX;
   wire wr_den = commit_w && aw_idx_q == DEN_IDX;
   wire wr_efs = commit_w && aw_idx_q == EFS_IDX;
   wire wr_gate = commit_w && aw_idx_q == GATE_IDX;
   wire wr_evt = commit_w && aw_idx_q == EVT_IDX;
   wire [15:0] m_ratio = merge16({2'h0, cfg_q.outdiv, 5'h00, cfg_q.vco},
      wdata_q, wstrb_q);
   wire [15:0] m_intg = merge16({1'h0, cfg_q.n, 1'h0, cfg_q.gain},
      wdata_q, wstrb_q);
   wire [15:0] m_ref = merge16({11'h000, cfg_q.presc, cfg_q.low_ref,
      cfg_q.src}, wdata_q, wstrb_q);
   // Writing zero to apply does nothing
   wire apply_w = wr_sw & wstrb_q[0] & wdata_q[APPLY_BIT];
   wire clr_w = wr_evt & wstrb_q[0] & wdata_q[DONE_BIT];

   always_comb begin
      cfg_d = cfg_q;
      // Stored fields always take writes; active copy is separate
      if (wr_ratio) begin
         cfg_d.outdiv = m_ratio[OUTDIV_LSB +: 6];
         cfg_d.vco = m_ratio[VCO_LSB +: 3];
      end
      if (wr_num) cfg_d.num = merge16(cfg_q.num, wdata_q, wstrb_q);
      if (wr_intg) begin
         cfg_d.n = m_intg[N_LSB +: 10];
         cfg_d.gain = m_intg[GAIN_LSB +: 4];
      end
      if (wr_ref) begin
         cfg_d.presc = m_ref[PRESC_LSB +: 2];
         cfg_d.low_ref = m_ref[LOWREF_BIT];
         cfg_d.src = m_ref[SRC_LSB +: 2];
      end
      if (wr_den) cfg_d.den = merge16(cfg_q.den, wdata_q, wstrb_q);
      if (wr_efs && wstrb_q[0]) begin
         cfg_d.dither = wdata_q[DITHER_LSB +: 2];
         cfg_d.frac = wdata_q[FRAC_BIT];
      end
   end

   // Read path
   wire [IDX_W-1:0] ar_idx = s_axi_araddr[ADDR_W-1:2];
   wire ar_hs = s_axi_arvalid & arready_q;
   wire ar_hit = (ar_idx >= RUN_IDX) && (ar_idx <= EVT_IDX);
   logic [15:0] rd_word;
   always_comb begin
      rd_word = 16'h0000;
      if (ar_idx == RUN_IDX) rd_word[RUN_BIT] = run_q;
      else if (ar_idx == RATIO_IDX)
         rd_word = {2'h0, cfg_q.outdiv, 5'h00, cfg_q.vco};
      else if (ar_idx == NUM_IDX) rd_word = cfg_q.num;
      else if (ar_idx == INTG_IDX)
         rd_word = {1'h0, cfg_q.n, 1'h0, cfg_q.gain};
      else if (ar_idx == REF_IDX)
         rd_word = {11'h000, cfg_q.presc, cfg_q.low_ref, cfg_q.src};
      else if (ar_idx == SW_IDX)
         rd_word[STS_LSB +: 2] = act_q.src;
      else if (ar_idx == DEN_IDX) rd_word = cfg_q.den;
      else if (ar_idx == EFS_IDX)
         rd_word = {13'h0000, cfg_q.dither, cfg_q.frac};
      else if (ar_idx == GATE_IDX)
         rd_word = {14'h0000, gpio_sel_q, gate_q};
      else if (ar_idx == EVT_IDX) rd_word[DONE_BIT] = flag_q;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'h0;
         w_have_q <= 1'h0;
         awready_q <= 1'h1;
         wready_q <= 1'h1;
         bvalid_q <= 1'h0;
         bresp_q <= RESP_OKAY;
         aw_idx_q <= '0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         sync_cnt_q <= 2'h0;
      end else begin
         sync_cnt_q <= sync_cnt_d;
         if (s_axi_awvalid && awready_q) begin
            aw_have_q <= 1'h1;
            awready_q <= 1'h0;
            aw_idx_q <= s_axi_awaddr[ADDR_W-1:2];
         end
         if (s_axi_wvalid && wready_q) begin
            w_have_q <= 1'h1;
            wready_q <= 1'h0;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (commit_w) begin
            bvalid_q <= 1'h1;
            bresp_q <= hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'h0;
            aw_have_q <= 1'h0;
            w_have_q <= 1'h0;
            awready_q <= 1'h1;
            wready_q <= 1'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'h1;
         rvalid_q <= 1'h0;
         rdata_q <= 32'h00000000;
         rresp_q <= RESP_OKAY;
      end else if (ar_hs) begin
         arready_q <= 1'h0;
         rvalid_q <= 1'h1;
         rdata_q <= {16'h0000, rd_word};
         rresp_q <= ar_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         arready_q <= 1'h1;
         rvalid_q <= 1'h0;
      end
   end

   // Control bits and stored configuration
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_q <= 1'h0;
         gate_q <= 1'h0;
         gpio_sel_q <= 1'h0;
         cfg_q <= '{SRC_RST, PRESC_RST, LOWREF_RST, OUTDIV_RST, VCO_RST,
            NUM_RST, N_RST, GAIN_RST, DEN_RST, DITHER_RST, FRAC_RST};
      end else begin
         cfg_q <= cfg_d;
         if (wr_run && wstrb_q[0]) run_q <= wdata_q[RUN_BIT];
         if (wr_gate && wstrb_q[0]) begin
            gate_q <= wdata_q[GATE_BIT];
            gpio_sel_q <= wdata_q[GPIO_SEL_BIT];
         end
      end
   end

   // Reference switch sequencing
   wire done_set = (st_q == ST_SWITCH) & run_q & seen_old_q &
      refs.rise[pend_src_q];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ST_IDLE;
         act_q <= '{SRC_RST, PRESC_RST, LOWREF_RST, OUTDIV_RST, VCO_RST,
            NUM_RST, N_RST, GAIN_RST, DEN_RST, DITHER_RST, FRAC_RST};
         pend_src_q <= SRC_RST;
         seen_old_q <= 1'h0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (!run_q) begin
                  act_q <= cfg_q;
               end else if (apply_w) begin
                  // Old source stays in use until the new one is seen
                  act_q <= '{act_q.src, cfg_q.presc, cfg_q.low_ref,
                     cfg_q.outdiv, cfg_q.vco, cfg_q.num, cfg_q.n,
                     cfg_q.gain, cfg_q.den, cfg_q.dither,
                     cfg_q.frac};
                  pend_src_q <= cfg_q.src;
                  seen_old_q <= 1'h0;
                  st_q <= ST_SWITCH;
               end
            end
            ST_SWITCH: begin
               if (!run_q) begin
                  st_q <= ST_IDLE;
               end else begin
                  // Relies on both references still toggling
                  if (refs.rise[act_q.src]) seen_old_q <= 1'h1;
                  if (done_set) begin
                     act_q.src <= pend_src_q;
                     st_q <= ST_IDLE;
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Divided reference and derived ratios
   wire rise_cur = refs.rise[act_q.src];
   wire [2:0] pmask = 3'((4'h1 << act_q.presc) - 4'h1);
   wire tick_d = run_q & rise_cur & ((pcnt_q & pmask) == pmask);
   wire [4:0] vco_d = act_q.vco[2] ? 5'h10 :
      5'(5'h1 << act_q.vco[1:0]);
   wire [6:0] ratio_d = {1'h0, act_q.outdiv} + 7'h01;
   // Codes above eight are undefined; clamp to the top gain
   wire [8:0] gain_d = (act_q.gain > 4'h8) ? 9'h100 :
      9'(9'h001 << act_q.gain);
   // Set wins over a clear in the same cycle
   wire flag_d = (flag_q & ~clr_w) | done_set;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pcnt_q <= 3'h0;
         tick_q <= 1'h0;
         vco_mult_q <= 5'h01;
         out_ratio_q <= 7'h01;
         gain_q <= 9'h001;
         flag_q <= 1'h0;
         done_q <= 1'h0;
         gpio_q <= 1'h0;
      end else begin
         pcnt_q <= !run_q ? 3'h0 : (rise_cur ? pcnt_q + 3'h1 : pcnt_q);
         tick_q <= tick_d;
         vco_mult_q <= vco_d;
         out_ratio_q <= ratio_d;
         gain_q <= gain_d;
         flag_q <= flag_d;
         done_q <= done_set;
         gpio_q <= gpio_sel_q ? flag_d : done_set;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign loop_run = run_q;
   assign ref_tick = tick_q;
   assign loop_ref_active_status = act_q.src;
   assign vco_mult = vco_mult_q;
   assign out_ratio = out_ratio_q;
   assign loop_integer_mult = act_q.n;
   assign loop_frac_numerator = act_q.num;
   assign loop_frac_denominator = act_q.den;
   assign loop_fractional_on = act_q.frac;
   assign loop_dither_select = act_q.dither;
   assign err_gain_mult = gain_q;
   assign loop_low_ref_mode = act_q.low_ref;
   assign switch_done_pulse = done_q;
   assign loop_switch_done_flag = flag_q;
   assign switch_gpio = gpio_q;

   // Checks
   gated_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (both_w && gate_q && sync_cnt_q == 2'h0) |->
      !commit_w ##1 !commit_w ##1 commit_w)
      else $error("gated write not delayed by two cycles");
   ungated_fast_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (both_w && !gate_q) |-> commit_w ##1 bvalid_q)
      else $error("ungated write not committed at once");
   idle_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!run_q && st_q == ST_IDLE) |=> act_q == $past(cfg_q))
      else $error("stopped loop does not follow stored config");
   shadow_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (run_q && st_q == ST_IDLE && !apply_w) |=> $stable(act_q))
      else $error("active config changed without apply");
   status_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ar_hs && ar_idx == SW_IDX) |=> s_axi_rvalid &&
      s_axi_rdata[3:2] == $past(act_q.src) && !s_axi_rdata[0])
      else $error("status read wrong");
   done_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
      done_set |=> switch_done_pulse && loop_switch_done_flag &&
      loop_ref_active_status == $past(pend_src_q))
      else $error("switch completion not signalled");
   switch_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_q == ST_SWITCH && !done_set) |=> $stable(act_q.src))
      else $error("reference changed before new edge");
   ratio_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (act_q.vco[2] && act_q.outdiv == 6'h07) |=>
      vco_mult == 5'h10 && out_ratio == 7'h08)
      else $error("ratio decode wrong");
   gain_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (act_q.gain == 4'h5) |=> err_gain_mult == 9'h020)
      else $error("gain decode wrong");
endmodule
`default_nettype wire

// file: fcs_pkg.sv
// Constants, register map and types for the loop clock synth control.
// Assumes a 32-bit AXI4-Lite slave; register index times four is the address.
package fcs_pkg;
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;
   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] RUN_IDX = 10'h220;
   localparam logic [IDX_W-1:0] RATIO_IDX = 10'h221;
   localparam logic [IDX_W-1:0] NUM_IDX = 10'h222;
   localparam logic [IDX_W-1:0] INTG_IDX = 10'h223;
   localparam logic [IDX_W-1:0] REF_IDX = 10'h224;
   localparam logic [IDX_W-1:0] SW_IDX = 10'h225;
   localparam logic [IDX_W-1:0] DEN_IDX = 10'h226;
   localparam logic [IDX_W-1:0] EFS_IDX = 10'h227;
   localparam logic [IDX_W-1:0] GATE_IDX = 10'h228;
   localparam logic [IDX_W-1:0] EVT_IDX = 10'h229;
   // Field positions
   localparam int RUN_BIT = 0;
   localparam int OUTDIV_LSB = 8;
   localparam int VCO_LSB = 0;
   localparam int N_LSB = 5;
   localparam int GAIN_LSB = 0;
   localparam int PRESC_LSB = 3;
   localparam int LOWREF_BIT = 2;
   localparam int SRC_LSB = 0;
   localparam int STS_LSB = 2;
   localparam int APPLY_BIT = 0;
   localparam int DITHER_LSB = 1;
   localparam int FRAC_BIT = 0;
   localparam int GATE_BIT = 0;
   localparam int GPIO_SEL_BIT = 1;
   localparam int DONE_BIT = 0;
   // Values after reset
   localparam logic [9:0] N_RST = 10'h2EE;
   localparam logic [5:0] OUTDIV_RST = 6'h00;
   localparam logic [2:0] VCO_RST = 3'h0;
   localparam logic [3:0] GAIN_RST = 4'h0;
   localparam logic [1:0] PRESC_RST = 2'h0;
   localparam logic LOWREF_RST = 1'h1;
   localparam logic [1:0] SRC_RST = 2'h0;
   localparam logic [15:0] NUM_RST = 16'h0000;
   localparam logic [15:0] DEN_RST = 16'h0000;
   localparam logic [1:0] DITHER_RST = 2'h1;
   localparam logic FRAC_RST = 1'h0;
   // Extra cycles a write waits while the core clock gate is set
   localparam logic [1:0] WR_SYNC_CYC = 2'h2;
   // Reference codes
   localparam logic [1:0] REF_MCLK_A = 2'h0;
   localparam logic [1:0] REF_MCLK_B = 2'h1;
   localparam logic [1:0] REF_FRAME_A = 2'h2;
   localparam logic [1:0] REF_BIT_A = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] src;
      logic [1:0] presc;
      logic low_ref;
      logic [5:0] outdiv;
      logic [2:0] vco;
      logic [15:0] num;
      logic [9:0] n;
      logic [3:0] gain;
      logic [15:0] den;
      logic [1:0] dither;
      logic frac;
   } fcs_cfg_t;

   typedef enum logic {ST_IDLE, ST_SWITCH} fcs_sw_t;
endpackage

// file: fcs_ref_if.sv
// Carrier for synchronised reference rising edges.
// Driven by the reference synchroniser, read by the control core.
`timescale 1ns/1ns
`default_nettype none
interface fcs_ref_if;
   logic [3:0] rise;
   modport src (output rise);
   modport dst (input rise);
endinterface
`default_nettype wire

// file: fcs_ref_src.sv
// Reference clock sources standing at the far side of the control core.
// Assumes nothing; each source runs only while its enable is high.
`timescale 1ns/1ns
`default_nettype none
module fcs_ref_src (
   // Enables, indexed by reference code
   input wire logic [3:0] run_en,
   // Reference clocks, indexed by reference code
   output logic [3:0] clk_out
);
   // Different half periods of 40 to 70 ns; edges of two sources still coincide at times
   for (genvar i = 0; i < 4; i++) begin : g_src
      always begin
         #(40 + 10 * i);
         // All sources keep toggling through any switch
         clk_out[i] = run_en[i] && clk_out[i] !== 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: fcs_ref_sync.sv
// Two-flop synchronisers and rise detectors for the four reference pins.
// Assumes references are well below half the aclk rate.
`timescale 1ns/1ns
`default_nettype none
module fcs_ref_sync import fcs_pkg::*; (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Reference pins, indexed by reference code
   input wire logic [3:0] ref_pins,
   // Rising edges out
   fcs_ref_if.src refs
);
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] s3_q;

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_ref
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               s1_q[i] <= 1'h0;
               s2_q[i] <= 1'h0;
               s3_q[i] <= 1'h0;
            end else begin
               s1_q[i] <= ref_pins[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
            end
         end
         // Edge detector looks only past the first flop
         assign refs.rise[i] = s2_q[i] & ~s3_q[i];
      end
   endgenerate
endmodule
`default_nettype wire

// file: fll_clock_synth_control_tb_top.sv
// Self-checking bench for the loop clock synth control core.
// Assumes fcs_pkg, fcs_ref_if, fcs_ref_sync and the reference source model.
`timescale 1ns/1ns
`default_nettype none
module fll_clock_synth_control_tb_top import fcs_pkg::*;;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, run, flag, gpio;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, ref_en, refs;
   logic [1:0] bresp, rresp, sts;
   logic [4:0] vco;
   logic [6:0] ratio;
   logic [9:0] nmul;
   logic [8:0] gain;
   logic pulse, tick, frac_on, low_ref;
   logic [1:0] dither;
   logic [15:0] num_a, den_a;
   int bad_count, tests_run, lat;

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   fcs_ref_src src_u (.run_en(ref_en), .clk_out(refs));

   fcs_ctrl dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .master_clk_in_a(refs[0]), .master_clk_in_b(refs[1]),
      .frame_clk_in_a(refs[2]), .bit_clk_in_a(refs[3]),
      .loop_run(run), .ref_tick(tick), .loop_ref_active_status(sts),
      .vco_mult(vco), .out_ratio(ratio), .loop_integer_mult(nmul),
      .loop_frac_numerator(num_a), .loop_frac_denominator(den_a),
      .loop_fractional_on(frac_on), .loop_dither_select(dither),
      .err_gain_mult(gain),
      .loop_low_ref_mode(low_ref), .switch_done_pulse(pulse),
      .loop_switch_done_flag(flag), .switch_gpio(gpio));

   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // A stuck handshake or switch ends the run at once
   task automatic hang_check(input int n);
      if (n >= 100) begin
         bad_count++;
         give_verdict();
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [15:0] d,
         input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr <= {idx, 2'h0};
      wdata <= {16'h0000, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      hang_check(n);
      bready <= 1'b0;
      lat = n;
      chk("bresp", 32'(er), 32'(bresp));
   endtask

   task automatic rd(input logic [9:0] idx, input logic [15:0] exp,
         input logic [1:0] er);
      int n;
      @(posedge aclk);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      hang_check(n);
      rready <= 1'b0;
      chk("rdata", {16'h0000, exp}, rdata);
      chk("rresp", 32'(er), 32'(rresp));
   endtask

   task automatic wait_done();
      int n;
      for (n = 0; n < 100 && flag !== 1'b1; n++) @(posedge aclk);
      hang_check(n);
   endtask

   task automatic t_reset();
      rd(RATIO_IDX, 16'h0000, RESP_OKAY);
      rd(INTG_IDX, 16'h5DC0, RESP_OKAY);
      rd(DEN_IDX, 16'h0000, RESP_OKAY);
      rd(EFS_IDX, 16'h0002, RESP_OKAY);
      chk("n active", 32'h2EE, 32'(nmul));
      chk("num active", 0, 32'(num_a));
      chk("den active", 0, 32'(den_a));
      chk("frac active", 0, 32'(frac_on));
   endtask

   // Loop stopped, so the active fields follow one cycle behind
   task automatic t_decode();
      int i;
      for (i = 0; i <= 8; i++) begin
         wr(RATIO_IDX, 16'(i * 7 * 256 + i % 8), RESP_OKAY);
         wr(INTG_IDX, 16'(i * 32 + i), RESP_OKAY);
         repeat (2) @(posedge aclk);
         chk("vco mult", i % 8 >= 4 ? 16 : 1 << (i % 4), 32'(vco));
         chk("out ratio", i * 7 + 1, 32'(ratio));
         chk("gain", 1 << i, 32'(gain));
         chk("n active", i, 32'(nmul));
      end
      // Low reference setting: vco ratio 16, output ratio 8
      wr(RATIO_IDX, 16'h0704, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("vco mult", 16, 32'(vco));
      chk("out ratio", 8, 32'(ratio));
   endtask

   task automatic t_switch();
      int k;
      int ticks;
      wr(GATE_IDX, 16'h0002, RESP_OKAY);
      // Bandgap is outside the model, so no settling wait is due
      wr(RUN_IDX, 16'h0001, RESP_OKAY);
      chk("run", 1, 32'(run));
      wr(INTG_IDX, 16'h0AA0, RESP_OKAY);
      wr(REF_IDX, 16'(REF_MCLK_B), RESP_OKAY);
      wr(SW_IDX, 16'h0000, RESP_OKAY);
      // Long enough for several edges of every source
      repeat (40) @(posedge aclk);
      chk("n shadowed", 8, 32'(nmul));
      rd(SW_IDX, 16'h0000, RESP_OKAY);
      for (k = 1; k <= 4; k++) begin
         // Output shows the flag on odd passes, the pulse on even ones
         wr(GATE_IDX, 16'(k % 2 * 2), RESP_OKAY);
         // Last pass also halves source A
         wr(REF_IDX, 16'(k % 4 + k / 4 * 8), RESP_OKAY);
         wr(SW_IDX, 16'h0001, RESP_OKAY);
         wait_done();
         chk("gpio", 1, 32'(gpio));
         chk("done pulse", 1, 32'(pulse));
         chk("status", k % 4, 32'(sts));
         chk("low ref", 0, 32'(low_ref));
         @(posedge aclk);
         chk("gpio held", k % 2, 32'(gpio));
         chk("pulse width", 0, 32'(pulse));
         rd(SW_IDX, 16'((k % 4) * 4), RESP_OKAY);
         wr(EVT_IDX, 16'h0001, RESP_OKAY);
         chk("flag clear", 0, 32'(flag));
      end
      chk("n applied", 32'h55, 32'(nmul));
      // Source A period is 8 cycles; halved it ticks every 16 cycles
      ticks = 0;
      repeat (80) begin
         @(posedge aclk);
         ticks += int'(tick);
      end
      chk("tick count", 5, ticks);
      wr(RUN_IDX, 16'h0000, RESP_OKAY);
      chk("run", 0, 32'(run));
   endtask

   task automatic t_gated();
      int base;
      wr(NUM_IDX, 16'h1111, RESP_OKAY);
      base = lat;
      wr(GATE_IDX, 16'h0001, RESP_OKAY);
      wr(NUM_IDX, 16'h1234, RESP_OKAY);
      chk("sync delay", 2, lat - base);
      rd(NUM_IDX, 16'h1234, RESP_OKAY);
      wr(DEN_IDX, 16'h1235, RESP_OKAY);
      wr(EFS_IDX, 16'h0007, RESP_OKAY);
      @(posedge aclk);
      chk("num active", 32'h1234, 32'(num_a));
      chk("den active", 32'h1235, 32'(den_a));
      chk("frac active", 1, 32'(frac_on));
      chk("dither active", 3, 32'(dither));
      wr(GATE_IDX, 16'h0000, RESP_OKAY);
      wr(10'h3FF, 16'hFFFF, RESP_SLVERR);
      rd(10'h3FF, 16'h0000, RESP_SLVERR);
   endtask

   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      ref_en = 4'hF;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_decode();
      t_switch();
      t_gated();
      give_verdict();
   end
endmodule
`default_nettype wire
